// ---- verification/cockpit_model.sv ----
// cockpit and console equipment: switches, encoders, meter strobe count
`timescale 1ns/1ps
module cockpit_model (
  input  wire logic         clk_in,      // system clock
  input  wire logic         dac_load_in, // converter strobe
  output logic [63:0]       din_out,     // switch bank
  output logic [239:0]      ain_out,     // shaft encoder codes
  output int                loads_out    // converter updates seen
);
  // switches and encoders held still while the program runs
  initial begin
    din_out = 64'hA5A5_0F0F_3C3C_9696;
    ain_out = {24{10'h2AA}};
    loads_out = 0;
  end
  // count each meter update pulse
  always @(posedge clk_in) begin
    if (dac_load_in === 1'b1) loads_out <= loads_out + 1;
  end
endmodule : cockpit_model

// ---- verification/tb_top.sv ----
// self-checking bench for the processor control
`timescale 1ns/1ps
module tb_top;
  logic        clk = 0, rst_n = 0, awvalid = 0, wvalid = 0;
  logic        bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd;
  logic [3:0]  wstrb = 4'hF;
  logic [20:0] a, b, r;
  wire logic   awready, wready, bvalid, arready, rvalid, dac_ld, perr;
  wire logic [1:0]   bresp, rresp;
  wire logic [31:0]  rdata;
  wire logic [63:0]  din;
  wire logic [239:0] ain;
  wire logic [23:0]  dout;
  wire logic [11:0]  dac;
  wire logic [5:0]   dch;
  wire logic [21:0]  prt;
  int          loads, n0, n, miscompares = 0, num_checks = 0, seed = 44;
  localparam logic [17:0] PROG [8] = '{{cpu_pkg::OP_LDA, 12'h00A},
    {cpu_pkg::OP_ADD, 12'h00B}, {cpu_pkg::OP_STO, 12'h00C},
    {cpu_pkg::OP_DOT, 12'h005}, {cpu_pkg::OP_PRT, 12'h000},
    {cpu_pkg::OP_AOT, 12'h007}, {6'h20, 12'h000}, {cpu_pkg::OP_HLT, 12'h000}};
  // 40 MHz clock
  always #12.5 clk = ~clk;
  cpu_ctrl #(.DIV_CYC(8)) dut (.clk_in(clk), .rst_n_in(rst_n), .ce_in(1'b1),
    .awvalid_in(awvalid), .awready_out(awready), .awaddr_in(awaddr),
    .wvalid_in(wvalid), .wready_out(wready), .wdata_in(wdata),
    .wstrb_in(wstrb), .bvalid_out(bvalid), .bready_in(bready),
    .bresp_out(bresp), .arvalid_in(arvalid), .arready_out(arready),
    .araddr_in(araddr), .rvalid_out(rvalid), .rready_in(rready),
    .rdata_out(rdata), .rresp_out(rresp), .din_in(din), .ain_in(ain),
    .dout_out(dout), .dac_out(dac), .dac_chan_out(dch),
    .dac_load_out(dac_ld), .print_out(prt), .par_err_out(perr));
  cockpit_model mdl (.clk_in(clk), .dac_load_in(dac_ld), .din_out(din),
    .ain_out(ain), .loads_out(loads));
  // sign-magnitude sum of two number words
  function automatic logic [20:0] smadd(input logic [20:0] x, y);
    if (x[20] == y[20]) return {x[20], x[19:0] + y[19:0]};
    if (x[19:0] > y[19:0]) return {x[20], x[19:0] - y[19:0]};
    return {y[20], y[19:0] - x[19:0]};
  endfunction : smadd
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  // one write, address and data offered together, each held until taken
  task automatic axw(input logic [7:0] ad, input logic [31:0] d,
                     input logic [3:0] s = 4'hF);
    int k;
    awaddr <= ad;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      k++;
    end while (bvalid !== 1'b1 && k < 60);
    bready <= 1'b0;
    if (k >= 60) begin
      chk(1'b0, "write timeout");
      print_verdict();
    end
    @(posedge clk);
  endtask : axw
  // one read, data taken at the edge that sees rvalid
  task automatic axr(input logic [7:0] ad);
    int k;
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      k++;
    end while (rvalid !== 1'b1 && k < 60);
    rd = rdata;
    rready <= 1'b0;
    if (k >= 60) begin
      chk(1'b0, "read timeout");
      print_verdict();
    end
    @(posedge clk);
  endtask : axr
  // main sequence: reset, bus corners, then program runs
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    axr(cpu_pkg::R_SEQ);
    chk(rd === 32'h0, "counter after reset");
    axr(cpu_pkg::R_STAT);
    chk(rd === 32'h0, "status after reset");
    axr(8'h20);
    chk(rresp === 2'h2 && rd === 32'h0, "unmapped read");
    axw(cpu_pkg::R_SEQ, 32'h5, 4'h1);
    axr(cpu_pkg::R_SEQ);
    chk(rd === 32'h0, "partial strobe write");
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? 21'h07FFFF : 21'($random(seed)) & 21'h17FFFF;
      b = (i == 0) ? 21'h100001 : 21'($random(seed)) & 21'h17FFFF;
      r = smadd(a, b);
      for (int j = 0; j < 8; j++) begin
        axw(cpu_pkg::R_LDA, j);
        axw(cpu_pkg::R_IMEM, {14'h0, PROG[j]});
      end
      axr(cpu_pkg::R_IMEM);
      chk(^rd[19:0] === 1'b1 && rd[21:20] === 2'h0, "order parity");
      axw(cpu_pkg::R_LDA, 32'h00A);
      axw(cpu_pkg::R_NMEM, {11'h0, a});
      axw(cpu_pkg::R_LDA, 32'h00B);
      axw(cpu_pkg::R_NMEM, {11'h0, b});
      axr(cpu_pkg::R_NMEM);
      chk(^rd[21:0] === 1'b1, "number parity");
      axw(cpu_pkg::R_SEQ, 32'h0);
      n0 = loads;
      axw(cpu_pkg::R_CTRL, 32'h1);
      n = 0;
      do begin
        axr(cpu_pkg::R_STAT);
        n++;
      end while (rd[1] !== 1'b0 && n < 1000);
      if (n >= 1000) begin
        chk(1'b0, "run timeout");
        print_verdict();
      end
      chk(rd[3:2] === 2'b10, "illegal order flag");
      axr(cpu_pkg::R_ACC);
      chk(rd[20:0] === r, "accumulator sum");
      axw(cpu_pkg::R_LDA, 32'h00C);
      axr(cpu_pkg::R_NMEM);
      chk(rd[20:0] === r && ^rd[21:0] === 1'b1, "stored sum");
      chk(dout[5] === r[20], "discrete output");
      chk(prt[20:0] === r && ^prt === 1'b1, "print word");
      chk(dac === {r[20], r[19:9]} && dch === 6'h07, "dac");
      chk(loads === n0 + 1, "dac strobe count");
      axw(cpu_pkg::R_CTRL, 32'h2);
    end
    print_verdict();
  end
endmodule : tb_top

// ---- verilog/cpu_ctrl.sv ----
// overlapped fixed-point processor control with axi4-lite access
`timescale 1ns/1ps
// Behaviour
// - low 20 bits magnitude, bit 20 sign, one means negative
// - top bit of each stored word makes the count of ones odd
// - numbers are fractions below one, point above magnitude msb
// - instruction words are 20 bits, one instruction, upper bits unused
// - operand address is low 12 bits, order code six bits above
// - next bit selects relative addressing, last bit is odd parity
// - only 32 of 64 order codes execute
// - add or subtract with fetch completes in one 5 us order time
// - multiply 10 us, divide 105 us, others one order time
// - separate 4096-word instruction and number memories, time-phased
// - next instruction and operand fetched while current executes
// - twelve-stage counter feeds instruction address register, starts read
// - fetched word latched, order field decoded, execution launched
// - direct mode: address field loads number address register unchanged
// - relative mode routes a modified address to number memory
// - results go to transfer register, then memory, dac, print, tally
// - discrete output bit set from accumulator sign at execution
// - 64 testable discrete input bits
// - 24 analog inputs, 10-bit inverted gray shaft codes
// - one 12-bit converter value routed to one of 64 channels
// - 22-bit print register, each stage drives an output flip-flop
// - parity formed on write, checked on use, mismatch flagged
// - relative bit of an instruction applies to the following one
// - relative address is field plus or minus index register
module cpu_ctrl #(
  parameter int DIV_CYC = cpu_pkg::DIV_CYC  // divide length in cycles
) (
  input  wire logic        clk_in,         // 40 MHz clock
  input  wire logic        rst_n_in,       // async reset, low
  input  wire logic        ce_in,          // clock enable
  input  wire logic        awvalid_in,     // axi write address
  output logic             awready_out,
  input  wire logic [7:0]  awaddr_in,
  input  wire logic        wvalid_in,      // axi write data
  output logic             wready_out,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wstrb_in,
  output logic             bvalid_out,     // axi write response
  input  wire logic        bready_in,
  output logic [1:0]       bresp_out,
  input  wire logic        arvalid_in,     // axi read address
  output logic             arready_out,
  input  wire logic [7:0]  araddr_in,
  output logic             rvalid_out,     // axi read data
  input  wire logic        rready_in,
  output logic [31:0]      rdata_out,
  output logic [1:0]       rresp_out,
  input  wire logic [63:0] din_in,         // discrete inputs
  input  wire logic [239:0] ain_in,        // 24 x 10 gray codes
  output logic [23:0]      dout_out,       // discrete outputs
  output logic [11:0]      dac_out,        // converter value
  output logic [5:0]       dac_chan_out,   // output channel
  output logic             dac_load_out,   // converter strobe
  output logic [21:0]      print_out,      // fast print stages
  output logic             par_err_out     // parity error flag
);
  logic [21:0] imem [cpu_pkg::MEM_D];
  logic [21:0] nmem [cpu_pkg::MEM_D];
  cpu_pkg::state_t st_r;
  logic [12:0] t_r;
  logic [11:0] seq_r, imar_r, nmar_r, cur_ea_r, idx_r, ld_addr_r;
  logic [21:0] nxt_ir_r, nxt_op_r, ir_r, opnd_r, acc_r, xfer_r;
  logic [21:0] tally_r;
  logic        idx_dec_r, rel_pend_r, run_r, ill_err_r;
  logic [63:0] din_s1_r, din_s2_r;
  logic [239:0] ain_s1_r, ain_s2_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;

  // odd parity for number and instruction words
  function automatic logic [21:0] npar(input logic [20:0] d);
    npar = {~^d, d};
  endfunction : npar
  function automatic logic [21:0] ipar(input logic [18:0] d);
    ipar = {2'b00, ~^d, d};
  endfunction : ipar
  // sign-magnitude to two's complement
  function automatic logic [21:0] to_tc(input logic [21:0] w);
    to_tc = w[20] ? 22'(-{2'b00, w[19:0]}) : {2'b00, w[19:0]};
  endfunction : to_tc
  function automatic logic [21:0] from_tc(input logic [21:0] s);
    logic [21:0] m;
    m = s[21] ? 22'(-s) : s;
    from_tc = npar({s[21], m[19:0]});
  endfunction : from_tc

  // decode of current word
  logic [5:0]  op;
  logic [12:0] dur;
  logic        done, start, ill, uses_op, sw_wr, idle;
  logic [11:0] nxt_ea;
  logic [39:0] prod, quot;
  logic [9:0]  gcode, gbin;
  assign op      = ir_r[cpu_pkg::OP_LSB +: cpu_pkg::OP_W];
  assign ill     = op[5];
  assign dur     = (op == cpu_pkg::OP_MUL) ? 13'(cpu_pkg::MUL_CYC) :
                   (op == cpu_pkg::OP_DIV) ? 13'(DIV_CYC) :
                   13'(cpu_pkg::ORDER_CYC);
  assign start   = (st_r == cpu_pkg::ST_EXEC) && (t_r == 13'h0000);
  assign done    = (st_r == cpu_pkg::ST_EXEC) && (t_r == dur - 13'h0001);
  assign uses_op = (op >= cpu_pkg::OP_LDA && op <= cpu_pkg::OP_DIV) ||
                   (op == cpu_pkg::OP_IDX);
  assign idle    = (st_r == cpu_pkg::ST_IDLE);
  // relative address of the next operand from index register
  assign nxt_ea  = !rel_pend_r ? nxt_ir_r[11:0] :
                   idx_dec_r ? nxt_ir_r[11:0] - idx_r :
                   nxt_ir_r[11:0] + idx_r;
  // fraction product keeps upper 20 bits; divide saturates on overflow
  assign prod = opnd_r[19:0] * acc_r[19:0];
  assign quot = (opnd_r[19:0] > acc_r[19:0]) ?
                {acc_r[19:0], 20'h00000} / {20'h00000, opnd_r[19:0]} :
                40'h00000FFFFF;
  // inverted gray to binary for the addressed channel
  assign gcode = ~ain_s2_r[cur_ea_r[4:0] * cpu_pkg::AIN_W +: cpu_pkg::AIN_W];
  genvar gi;
  generate
    for (gi = 0; gi < cpu_pkg::AIN_W; gi++) begin : g_gray
      assign gbin[gi] = ^gcode[cpu_pkg::AIN_W-1:gi];
    end
  endgenerate

  // two-stage synchronisers for pin inputs
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      din_s1_r <= 64'h0;
      din_s2_r <= 64'h0;
      ain_s1_r <= 240'h0;
      ain_s2_r <= 240'h0;
    end else if (ce_in) begin
      din_s1_r <= din_in;
      din_s2_r <= din_s1_r;
      ain_s1_r <= ain_in;
      ain_s2_r <= ain_s1_r;
    end
  end

  // sequencing: fill pipe, execute, overlap next fetch
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r       <= cpu_pkg::ST_IDLE;
      t_r        <= 13'h0000;
      seq_r      <= cpu_pkg::ADDR_RST;
      imar_r     <= cpu_pkg::ADDR_RST;
      nmar_r     <= cpu_pkg::ADDR_RST;
      cur_ea_r   <= cpu_pkg::ADDR_RST;
      nxt_ir_r   <= cpu_pkg::WORD_RST;
      nxt_op_r   <= cpu_pkg::WORD_RST;
      ir_r       <= cpu_pkg::WORD_RST;
      opnd_r     <= cpu_pkg::WORD_RST;
      rel_pend_r <= 1'b0;
      run_r      <= 1'b0;
    end else if (ce_in) begin
      case (st_r)
        cpu_pkg::ST_IDLE: begin
          t_r <= 13'h0000;
          if (sw_wr && awaddr_r == cpu_pkg::R_SEQ) begin
            seq_r <= wdata_r[11:0];
          end
          if (sw_wr && awaddr_r == cpu_pkg::R_CTRL && wdata_r[0]) begin
            run_r <= 1'b1;
            st_r  <= cpu_pkg::ST_FILL;
          end
        end
        cpu_pkg::ST_FILL, cpu_pkg::ST_EXEC: begin
          t_r <= t_r + 13'h0001;
          if (t_r == 13'h0000) begin
            imar_r <= seq_r;
            seq_r  <= seq_r + 12'h001;
          end
          if (t_r == 13'h0001) begin
            nxt_ir_r <= imem[imar_r];
          end
          if (t_r == 13'h0002) begin
            nmar_r <= nxt_ea;
          end
          if (t_r == 13'h0003) begin
            nxt_op_r <= nmem[nmar_r];
          end
          if (start) begin
            rel_pend_r <= ir_r[cpu_pkg::REL_BIT];
          end
          if (sw_wr && awaddr_r == cpu_pkg::R_CTRL && !wdata_r[0]) begin
            run_r <= 1'b0;
          end
          if (st_r == cpu_pkg::ST_FILL && t_r == 13'(cpu_pkg::FILL_CYC)) begin
            ir_r     <= nxt_ir_r;
            opnd_r   <= nxt_op_r;
            cur_ea_r <= nmar_r;
            t_r      <= 13'h0000;
            st_r     <= cpu_pkg::ST_EXEC;
          end
          // parity checked when the word is used
          if (start && ((^ir_r[19:0]) == 1'b0 ||
              (uses_op && (^opnd_r) == 1'b0))) begin
            run_r <= 1'b0;
            st_r  <= cpu_pkg::ST_IDLE;
          end
          if (done) begin
            ir_r     <= nxt_ir_r;
            opnd_r   <= (op == cpu_pkg::OP_STO && cur_ea_r == nmar_r) ?
                        xfer_r : nxt_op_r;
            cur_ea_r <= nmar_r;
            t_r      <= 13'h0000;
            if (op == cpu_pkg::OP_HLT || !run_r) begin
              run_r <= 1'b0;
              st_r  <= cpu_pkg::ST_IDLE;
            end else if (op == cpu_pkg::OP_JMP ||
                         (op == cpu_pkg::OP_JMN && acc_r[20])) begin
              seq_r <= cur_ea_r;
              st_r  <= cpu_pkg::ST_FILL;
            end else if (op == cpu_pkg::OP_DIN &&
                         din_s2_r[cur_ea_r[5:0]]) begin
              st_r <= cpu_pkg::ST_FILL;  // skip the prefetched word
            end
          end
        end
        default: st_r <= cpu_pkg::ST_IDLE;
      endcase
    end
  end

  // arithmetic and transfer register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_r     <= cpu_pkg::WORD_RST;
      xfer_r    <= cpu_pkg::WORD_RST;
      idx_r     <= cpu_pkg::ADDR_RST;
      idx_dec_r <= 1'b0;
    end else if (ce_in && done) begin
      case (op)
        cpu_pkg::OP_LDA: begin
          acc_r  <= opnd_r;
          xfer_r <= opnd_r;
        end
        cpu_pkg::OP_ADD, cpu_pkg::OP_SUB: begin
          acc_r  <= from_tc(to_tc(acc_r) + ((op == cpu_pkg::OP_SUB) ?
                    22'(-to_tc(opnd_r)) : to_tc(opnd_r)));
          xfer_r <= from_tc(to_tc(acc_r) + ((op == cpu_pkg::OP_SUB) ?
                    22'(-to_tc(opnd_r)) : to_tc(opnd_r)));
        end
        cpu_pkg::OP_MUL: begin
          acc_r  <= npar({acc_r[20] ^ opnd_r[20], prod[39:20]});
          xfer_r <= npar({acc_r[20] ^ opnd_r[20], prod[39:20]});
        end
        cpu_pkg::OP_DIV: begin
          acc_r  <= npar({acc_r[20] ^ opnd_r[20], quot[19:0]});
          xfer_r <= npar({acc_r[20] ^ opnd_r[20], quot[19:0]});
        end
        cpu_pkg::OP_AIN: begin
          acc_r  <= npar({1'b0, gbin, 10'h000});
          xfer_r <= npar({1'b0, gbin, 10'h000});
        end
        cpu_pkg::OP_IDX: begin
          idx_r     <= opnd_r[11:0];
          idx_dec_r <= opnd_r[20];
        end
        default: acc_r <= acc_r;
      endcase
    end
  end

  // memory write ports: processor stores, software loads while idle
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      if (done && op == cpu_pkg::OP_STO) begin
        nmem[cur_ea_r] <= npar(xfer_r[20:0]);
      end else if (sw_wr && idle && awaddr_r == cpu_pkg::R_NMEM) begin
        nmem[ld_addr_r] <= npar(wdata_r[20:0]);
      end
      if (done && op == cpu_pkg::OP_STI) begin
        imem[cur_ea_r] <= ipar(xfer_r[18:0]);
      end else if (sw_wr && idle && awaddr_r == cpu_pkg::R_IMEM) begin
        imem[ld_addr_r] <= ipar(wdata_r[18:0]);
      end
    end
  end

  // output registers driven by transfer and accumulator
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dout_out     <= 24'h000000;
      dac_out      <= 12'h000;
      dac_chan_out <= 6'h00;
      dac_load_out <= 1'b0;
      print_out    <= cpu_pkg::WORD_RST;
      tally_r      <= cpu_pkg::WORD_RST;
    end else if (ce_in) begin
      dac_load_out <= done && op == cpu_pkg::OP_AOT;
      if (done && op == cpu_pkg::OP_DOT && cur_ea_r < 12'(cpu_pkg::N_DOUT)) begin
        dout_out[cur_ea_r[4:0]] <= acc_r[cpu_pkg::SIGN_BIT];
      end
      if (done && op == cpu_pkg::OP_AOT) begin
        dac_out      <= {xfer_r[20], xfer_r[19:9]};
        dac_chan_out <= cur_ea_r[5:0];
      end
      if (done && op == cpu_pkg::OP_PRT) begin
        print_out <= xfer_r;
      end
      if (done && op == cpu_pkg::OP_TAL) begin
        tally_r <= xfer_r;
      end
    end
  end

  // error flags; setting wins over clearing
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      par_err_out <= 1'b0;
      ill_err_r   <= 1'b0;
    end else if (ce_in) begin
      if (start && ((^ir_r[19:0]) == 1'b0 ||
          (uses_op && (^opnd_r) == 1'b0))) begin
        par_err_out <= 1'b1;
      end else if (sw_wr && awaddr_r == cpu_pkg::R_CTRL && wdata_r[1]) begin
        par_err_out <= 1'b0;
      end
      if (start && ill) begin
        ill_err_r <= 1'b1;
      end else if (sw_wr && awaddr_r == cpu_pkg::R_CTRL && wdata_r[1]) begin
        ill_err_r <= 1'b0;
      end
    end
  end

  // axi4-lite write side
  assign sw_wr = !awready_out && !wready_out && !bvalid_out &&
                 (wstrb_r == 4'hF);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      awready_out <= 1'b1;
      wready_out  <= 1'b1;
      bvalid_out  <= 1'b0;
      bresp_out   <= 2'h0;
      awaddr_r    <= 8'h00;
      wdata_r     <= 32'h0;
      wstrb_r     <= 4'h0;
      ld_addr_r   <= cpu_pkg::ADDR_RST;
    end else if (ce_in) begin
      if (awvalid_in && awready_out) begin
        awaddr_r    <= awaddr_in;
        awready_out <= 1'b0;
      end
      if (wvalid_in && wready_out) begin
        wdata_r    <= wdata_in;
        wstrb_r    <= wstrb_in;
        wready_out <= 1'b0;
      end
      if (!awready_out && !wready_out && !bvalid_out) begin
        bvalid_out <= 1'b1;
        bresp_out  <= (awaddr_r[7:5] != 3'h0 || awaddr_r[1:0] != 2'h0) ?
                      2'h2 : 2'h0;
        if (sw_wr && awaddr_r == cpu_pkg::R_LDA) begin
          ld_addr_r <= wdata_r[11:0];
        end
      end
      if (bvalid_out && bready_in) begin
        bvalid_out  <= 1'b0;
        awready_out <= 1'b1;
        wready_out  <= 1'b1;
      end
    end
  end

  // axi4-lite read side
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      arready_out <= 1'b1;
      rvalid_out  <= 1'b0;
      rdata_out   <= 32'h0;
      rresp_out   <= 2'h0;
    end else if (ce_in) begin
      if (arvalid_in && arready_out) begin
        arready_out <= 1'b0;
        rvalid_out  <= 1'b1;
        rresp_out   <= 2'h0;
        case (araddr_in)
          cpu_pkg::R_CTRL: rdata_out <= {31'h0, run_r};
          cpu_pkg::R_STAT: rdata_out <= {28'h0, ill_err_r, par_err_out,
                                         !idle, run_r};
          cpu_pkg::R_SEQ:  rdata_out <= {20'h0, seq_r};
          cpu_pkg::R_ACC:  rdata_out <= {10'h0, acc_r};
          cpu_pkg::R_LDA:  rdata_out <= {20'h0, ld_addr_r};
          cpu_pkg::R_IMEM: rdata_out <= {10'h0, imem[ld_addr_r]};
          cpu_pkg::R_NMEM: rdata_out <= {10'h0, nmem[ld_addr_r]};
          cpu_pkg::R_TALY: rdata_out <= {10'h0, tally_r};
          default: begin
            rdata_out <= 32'h0;
            rresp_out <= 2'h2;
          end
        endcase
      end
      if (rvalid_out && rready_in) begin
        rvalid_out  <= 1'b0;
        arready_out <= 1'b1;
      end
    end
  end

  // cycles since the current order started, for the multiply length check
  logic [12:0] ord_cnt_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ord_cnt_r <= 13'h0000;
    end else if (ce_in) begin
      ord_cnt_r <= start ? 13'h0001 : ord_cnt_r + 13'h0001;
    end
  end

  // checks, valid with ce_in held high
  a_add_time: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    start && op == cpu_pkg::OP_ADD |-> ##199 done) else $error("add length");
  a_mul_time: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    done && op == cpu_pkg::OP_MUL |->
    ord_cnt_r == 13'(cpu_pkg::MUL_CYC - 1)) else $error("multiply length");
  a_seq_fetch: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && !idle && t_r == 13'h0000 |=> imar_r == $past(seq_r))
    else $error("fetch address");
  a_direct_addr: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && !idle && t_r == 13'h0002 && !rel_pend_r |=>
    nmar_r == $past(nxt_ir_r[11:0])) else $error("direct address");
  a_rel_addr: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && !idle && t_r == 13'h0002 && rel_pend_r && !idx_dec_r |=>
    nmar_r == $past(nxt_ir_r[11:0] + idx_r)) else $error("relative address");
  a_dout_sign: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && done && op == cpu_pkg::OP_DOT && cur_ea_r < 12'h018 |=>
    dout_out[$past(cur_ea_r[4:0])] == $past(acc_r[20])) else $error("dout");
  a_print_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && done && op == cpu_pkg::OP_PRT |=> print_out == $past(xfer_r))
    else $error("print load");
  a_par_halt: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && start && (^ir_r[19:0]) == 1'b0 |=> par_err_out && idle)
    else $error("parity halt");
  a_illegal_op: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && start && ill |=> ill_err_r) else $error("illegal order");
  c_add_done: cover property (@(posedge clk_in) done && op == cpu_pkg::OP_ADD);
  c_jump: cover property (@(posedge clk_in) done && op == cpu_pkg::OP_JMP);
  c_div_done: cover property (@(posedge clk_in) done && op == cpu_pkg::OP_DIV);
endmodule : cpu_ctrl

// ---- verilog/cpu_pkg.sv ----
// constants shared by the overlapped fixed-point processor control
package cpu_pkg;
  // timing
  localparam int CLK_NS    = 25;
  localparam int ORDER_NS  = 5000;
  localparam int MUL_NS    = 10000;
  localparam int DIV_NS    = 105000;
  localparam int ORDER_CYC = (ORDER_NS + CLK_NS - 1) / CLK_NS;
  localparam int MUL_CYC   = (MUL_NS + CLK_NS - 1) / CLK_NS;
  localparam int DIV_CYC   = (DIV_NS + CLK_NS - 1) / CLK_NS;
  localparam int FILL_CYC  = 4;
  // word layout
  localparam int WORD_W   = 22;
  localparam int MAG_W    = 20;
  localparam int SIGN_BIT = 20;
  localparam int PAR_BIT  = 21;
  localparam int ADDR_W   = 12;
  localparam int OP_LSB   = 12;
  localparam int OP_W     = 6;
  localparam int REL_BIT  = 18;
  localparam int IPAR_BIT = 19;
  localparam int MEM_D    = 4096;
  // i/o sizes
  localparam int N_DOUT = 24;
  localparam int N_DIN  = 64;
  localparam int N_AIN  = 24;
  localparam int AIN_W  = 10;
  localparam int DAC_W  = 12;
  localparam int ACH_W  = 6;
  // order codes; bit 5 set means not implemented
  localparam logic [5:0] OP_HLT = 6'h00;
  localparam logic [5:0] OP_LDA = 6'h01;
  localparam logic [5:0] OP_ADD = 6'h02;
  localparam logic [5:0] OP_SUB = 6'h03;
  localparam logic [5:0] OP_MUL = 6'h04;
  localparam logic [5:0] OP_DIV = 6'h05;
  localparam logic [5:0] OP_STO = 6'h06;
  localparam logic [5:0] OP_STI = 6'h07;
  localparam logic [5:0] OP_PRT = 6'h08;
  localparam logic [5:0] OP_AOT = 6'h09;
  localparam logic [5:0] OP_TAL = 6'h0A;
  localparam logic [5:0] OP_DOT = 6'h0B;
  localparam logic [5:0] OP_DIN = 6'h0C;
  localparam logic [5:0] OP_AIN = 6'h0D;
  localparam logic [5:0] OP_JMP = 6'h0E;
  localparam logic [5:0] OP_JMN = 6'h0F;
  localparam logic [5:0] OP_IDX = 6'h10;
  // register byte offsets
  localparam logic [7:0] R_CTRL = 8'h00;
  localparam logic [7:0] R_STAT = 8'h04;
  localparam logic [7:0] R_SEQ  = 8'h08;
  localparam logic [7:0] R_ACC  = 8'h0C;
  localparam logic [7:0] R_LDA  = 8'h10;
  localparam logic [7:0] R_IMEM = 8'h14;
  localparam logic [7:0] R_NMEM = 8'h18;
  localparam logic [7:0] R_TALY = 8'h1C;
  // reset values
  localparam logic [21:0] WORD_RST = 22'h000000;
  localparam logic [11:0] ADDR_RST = 12'h000;
  typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_EXEC} state_t;
endpackage : cpu_pkg
